// ---- hdl/ssiap_pkg.sv ----
// Shared constants and carrier types for the absolute position serial port.
// Assumes a 100 MHz core clock; link timing is counted in core cycles.
package ssiap_pkg;
    // Core clock
    localparam int CLK_PERIOD_NS  = 10;
    // Frame lengths, single and multi revolution
    localparam int ST_BITS        = 13;
    localparam int MT_BITS        = 25;
    localparam int MAX_BITS       = 25;
    // Counter width for all hold and recovery timers
    localparam int CNT_W          = 24;
    // Recovery interval plus optional extra clock pause
    localparam int RECOVERY_NS    = 20000;
    localparam int EXTRA_PAUSE_NS = 0;
    localparam int RECOVERY_CYC   =
        (RECOVERY_NS + EXTRA_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Programming input hold times, strictly longer than printed
    localparam int DIR_HOLD_NS    = 1000000;
    localparam int DIR_HOLD_CYC   = DIR_HOLD_NS / CLK_PERIOD_NS + 1;
    localparam int ZERO_HOLD_NS   = 12000000;
    localparam int ZERO_HOLD_CYC  = ZERO_HOLD_NS / CLK_PERIOD_NS + 1;
    // Buffer depth in the position path
    localparam int BUF_DEPTH      = 2;
    // Idle level of the data line
    localparam logic DATA_IDLE    = 1'b1;

    typedef logic [MAX_BITS-1:0] ssiap_word_t;

    typedef struct packed {
        ssiap_word_t count;
    } ssiap_pos_t;
endpackage

// ---- hdl/ssiap_buf.sv ----
// Two-entry valid/ready buffer for position samples.
// Assumes both sides run on core_clk with synchronous active-low reset.
`timescale 1ns/1ps
module ssiap_buf
    import ssiap_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Fill side
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire ssiap_pos_t in_data,
    // Drain side
    output logic            out_valid,
    input  wire logic       out_ready,
    output ssiap_pos_t      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int NW = $clog2(DEPTH + 1);

    typedef struct packed {
        ssiap_pos_t [DEPTH-1:0] mem;
        logic [AW-1:0]          wr;
        logic [AW-1:0]          rd;
        logic [NW-1:0]          num;
    } ssiap_buf_st_t;

    ssiap_buf_st_t st_r;
    ssiap_buf_st_t st_nxt;
    logic          push;
    logic          pop;

    assign in_ready  = (st_r.num != NW'(DEPTH));
    assign out_valid = (st_r.num != '0);
    assign out_data  = st_r.mem[st_r.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] i);
        wrap_inc = (i == AW'(DEPTH - 1)) ? '0 : AW'(i + 1'b1);
    endfunction

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr] = in_data;
            st_nxt.wr           = wrap_inc(st_r.wr);
        end
        if (pop) begin
            st_nxt.rd = wrap_inc(st_r.rd);
        end
        st_nxt.num = NW'(st_r.num + NW'(push) - NW'(pop));
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ---- hdl/ssiap_link.sv ----
// Link-side shifter, clocked by the controller's shift clock.
// Assumes the clock idles high and link_clr is raised only while it is idle.
`timescale 1ns/1ps
module ssiap_link #(
    parameter int FW = 13
) (
    // Link clock from the controller, clear from the core
    input  wire logic          link_clk,
    input  wire logic          link_clr,
    // Word and restart level from the core
    input  wire logic [FW-1:0] tx_word,
    input  wire logic          restart,
    // Serial bit towards the core
    output logic               dout
);
    localparam int CW = $clog2(FW + 1);

    typedef struct packed {
        logic          go_t;
        logic [FW-1:0] cap;
    } ssiap_neg_t;

    typedef struct packed {
        logic          ack_t;
        logic          busy;
        logic [CW-1:0] cnt;
        logic [FW-1:0] sh;
        logic          dout;
    } ssiap_lpos_t;

    localparam ssiap_lpos_t POS_RST = '{ack_t: 1'b0, busy: 1'b0, cnt: '0,
                                        sh: '0, dout: 1'b1};

    ssiap_neg_t  ns_r;
    ssiap_neg_t  ns_nxt;
    ssiap_lpos_t ps_r;
    ssiap_lpos_t ps_nxt;
    logic        take;

    // Word is Gray and stable in recovery, so a capture racing an update
    // can only land on one of two neighbouring values when the position moves by one step.
    assign take = (ns_r.go_t == ps_r.ack_t) && (!ps_r.busy || restart);
    assign dout = ps_r.dout;

    always_comb begin
        ns_nxt = ns_r;
        ps_nxt = ps_r;
        if (take) begin
            ns_nxt.cap  = tx_word;                     // [R8]
            ns_nxt.go_t = !ns_r.go_t;
        end
        if (ns_r.go_t != ps_r.ack_t) begin
            ps_nxt.ack_t = ns_r.go_t;
            ps_nxt.busy  = 1'b1;
            ps_nxt.cnt   = CW'(1);
            ps_nxt.dout  = ns_r.cap[FW-1];             // [R9]
            ps_nxt.sh    = ns_r.cap << 1;
        end else if (ps_r.busy) begin
            if (ps_r.cnt == CW'(FW)) begin             // [R2]
                ps_nxt.busy = 1'b0;
                ps_nxt.dout = 1'b0;                    // [R10]
            end else begin
                ps_nxt.dout = ps_r.sh[FW-1];           // [R1]
                ps_nxt.sh   = ps_r.sh << 1;
                ps_nxt.cnt  = CW'(ps_r.cnt + 1'b1);
            end
        end
    end

    always_ff @(negedge link_clk or posedge link_clr) begin
        if (link_clr) begin
            ns_r <= '0;
        end else begin
            ns_r <= ns_nxt;
        end
    end

    always_ff @(posedge link_clk or posedge link_clr) begin
        if (link_clr) begin
            ps_r <= POS_RST;
        end else begin
            ps_r <= ps_nxt;
        end
    end

    a_msb_first: assert property (@(posedge link_clk) disable iff (link_clr) // [R1]
        (ns_r.go_t != ps_r.ack_t) |=> (dout == $past(ns_r.cap[FW-1])))
        else $error("first bit after capture is not the word MSB");

    a_frame_len: assert property (@(posedge link_clk) disable iff (link_clr) // [R2]
        ps_r.busy |-> (ps_r.cnt != '0) && (ps_r.cnt <= CW'(FW)))
        else $error("bit count outside frame length");

    a_low_after: assert property (@(posedge link_clk) disable iff (link_clr) // [R10]
        (ps_r.busy && ps_r.cnt == CW'(FW) && ns_r.go_t == ps_r.ack_t)
        |=> (!ps_r.busy && !dout))
        else $error("data not low after last bit");

    a_hold_word: assert property (@(negedge link_clk) disable iff (link_clr) // [R12]
        (ps_r.busy && !restart) |=> $stable(ns_r.cap))
        else $error("captured word changed inside a frame");
endmodule

// ---- hdl/ssiap_port.sv ----
// Device end of the absolute position serial port: timers, position path,
// recovery handling and the data pin. Assumes the controller makes the
// shift clock, idles it high, and holds it high while rst_n is low.
`timescale 1ns/1ps

// What the link asks of this block and of the controller
// [R1] Shift position out MSB first, in step with controller's clock.
// [R2] Frame is 13 bits single-revolution, 25 bits multi-revolution.
// [R3] Transmitted word is Gray code; controller converts back to binary.
// [R4] Direction input high longer than 1 ms reverses counting sense.
// [R5] Default: values ascend clockwise; direction input switches this.
// [R6] Zero input rising edge held over 12 ms zeroes current position.
// [R7] Idle: controller holds clock high, device holds data high.
// [R8] First falling clock edge captures current position into shifter.
// [R9] Bits are presented from first rising edge after capture.
// [R10] After last bit data stays low until recovery interval ends.
// [R11] Some controllers add an extra clock pause after recovery.
// [R12] Clock resuming inside recovery retransmits the same word.
// [R13] Clock high for full recovery: next falling edge captures fresh value.
// [R14] Controller samples each bit on rising edges after capture; ssiap_ctrl_model samples half a clock later, just before each falling edge.
// [R15] Controller sets frame length and recovery, one pulse per bit.
module ssiap_port
    import ssiap_pkg::*;
#(
    parameter bit MULTITURN     = 1'b0,
    parameter int RECOVERY_CYCS = RECOVERY_CYC,
    parameter int DIR_CYCS      = DIR_HOLD_CYC,
    parameter int ZERO_CYCS     = ZERO_HOLD_CYC
) (
    // Core clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Serial link
    input  wire logic       link_clk,
    output logic            data_out,
    // Programming inputs
    input  wire logic       dir_pin,
    input  wire logic       zero_pin,
    // Position samples from the sensing logic
    input  wire logic       pos_valid,
    output logic            pos_ready,
    input  wire ssiap_pos_t pos_data,
    // Status
    output logic            dir_reversed,
    output logic            zero_done
);
    localparam int          FW      = MULTITURN ? MT_BITS : ST_BITS;
    localparam ssiap_word_t FW_MASK = ssiap_word_t'((64'd1 << FW) - 64'd1);

    typedef struct packed {
        logic        sclk_s1;
        logic        sclk_s2;
        logic        dout_s1;
        logic        dout_s2;
        logic        dir_s1;
        logic        dir_s2;
        logic        zero_s1;
        logic        zero_s2;
        logic        zero_prev;
        logic [CNT_W-1:0] rec_cnt;
        logic        recovered;
        logic [CNT_W-1:0] dir_cnt;
        logic        dir_rev;
        logic [CNT_W-1:0] zero_cnt;
        logic        zero_arm;
        logic        zero_fire;
        ssiap_word_t live;
        ssiap_word_t offset;
        ssiap_word_t tx_gray;
        logic        data_r;
        logic        link_clr;
    } ssiap_core_st_t;

    ssiap_core_st_t st_r;
    ssiap_core_st_t st_nxt;
    logic           link_dout;
    logic           buf_valid;
    logic           buf_pop;
    ssiap_pos_t     buf_data;
    logic           zero_hit;
    ssiap_word_t    diff;
    ssiap_word_t    rep;

    function automatic ssiap_word_t bin2gray(input ssiap_word_t b);
        bin2gray = b ^ (b >> 1);
    endfunction

    function automatic ssiap_word_t gray2bin(input ssiap_word_t g);
        ssiap_word_t b;
        b = g;
        for (int i = MAX_BITS - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        gray2bin = b;
    endfunction

    // Samples stall in the buffer while a word may be on the wire
    ssiap_buf u_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (pos_valid),
        .in_ready  (pos_ready),
        .in_data   (pos_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop),
        .out_data  (buf_data)
    );

    ssiap_link #(
        .FW (FW)
    ) u_link (
        .link_clk (link_clk),
        .link_clr (st_r.link_clr),
        .tx_word  (st_r.tx_gray[FW-1:0]),
        .restart  (st_r.recovered),
        .dout     (link_dout)
    );

    assign zero_hit = st_r.zero_arm && st_r.zero_s2
                      && (st_r.zero_cnt == CNT_W'(ZERO_CYCS - 1));
    assign buf_pop  = st_r.recovered && !zero_hit;
    assign diff     = ssiap_word_t'(st_r.live - st_r.offset);
    // Reversal mirrors around the zero point, so zero stays zero
    assign rep      = (st_r.dir_rev ? ssiap_word_t'('0 - diff) : diff) & FW_MASK; // [R5]

    assign data_out     = st_r.data_r;
    assign dir_reversed = st_r.dir_rev;
    assign zero_done    = st_r.zero_fire;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.sclk_s1  = link_clk;
        st_nxt.sclk_s2  = st_r.sclk_s1;
        st_nxt.dout_s1  = link_dout;
        st_nxt.dout_s2  = st_r.dout_s1;
        st_nxt.dir_s1   = dir_pin;
        st_nxt.dir_s2   = st_r.dir_s1;
        st_nxt.zero_s1  = zero_pin;
        st_nxt.zero_s2  = st_r.zero_s1;
        st_nxt.zero_prev = st_r.zero_s2;
        st_nxt.link_clr = 1'b0;
        st_nxt.zero_fire = 1'b0;

        // Recovery: any low clock restarts the interval
        if (!st_r.sclk_s2) begin
            st_nxt.rec_cnt   = '0;
            st_nxt.recovered = 1'b0;                   // [R12]
        end else if (st_r.rec_cnt != CNT_W'(RECOVERY_CYCS)) begin
            st_nxt.rec_cnt   = CNT_W'(st_r.rec_cnt + 1'b1);
            st_nxt.recovered = (st_nxt.rec_cnt == CNT_W'(RECOVERY_CYCS)); // [R13]
        end

        // Direction reversal only while held
        if (!st_r.dir_s2) begin
            st_nxt.dir_cnt = '0;
            st_nxt.dir_rev = 1'b0;
        end else if (st_r.dir_cnt != CNT_W'(DIR_CYCS)) begin
            st_nxt.dir_cnt = CNT_W'(st_r.dir_cnt + 1'b1);
            st_nxt.dir_rev = (st_nxt.dir_cnt == CNT_W'(DIR_CYCS)); // [R4]
        end

        // Zeroing needs a fresh rising edge each time
        if (!st_r.zero_s2) begin
            st_nxt.zero_cnt = '0;
            st_nxt.zero_arm = 1'b0;
        end else if (!st_r.zero_prev) begin
            st_nxt.zero_cnt = CNT_W'(1);
            st_nxt.zero_arm = 1'b1;
        end else if (zero_hit) begin
            st_nxt.zero_arm  = 1'b0;
            st_nxt.zero_fire = 1'b1;
            st_nxt.offset    = st_r.live;              // [R6]
        end else if (st_r.zero_arm) begin
            st_nxt.zero_cnt = CNT_W'(st_r.zero_cnt + 1'b1);
        end

        if (buf_valid && buf_pop) begin
            st_nxt.live = buf_data.count;
        end

        // Word follows position only in idle; frozen from the first low
        if (st_r.recovered && st_r.sclk_s2) begin
            st_nxt.tx_gray = bin2gray(rep);            // [R3]
        end

        st_nxt.data_r = st_r.recovered ? DATA_IDLE : st_r.dout_s2; // [R7]
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r           <= '0;
            st_r.sclk_s1   <= 1'b1;
            st_r.sclk_s2   <= 1'b1;
            st_r.dout_s1   <= DATA_IDLE;
            st_r.dout_s2   <= DATA_IDLE;
            st_r.rec_cnt   <= CNT_W'(RECOVERY_CYCS);
            st_r.recovered <= 1'b1;
            st_r.data_r    <= DATA_IDLE;
            st_r.link_clr  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Checking helpers
    logic [CNT_W-1:0] hi_cnt;
    logic [CNT_W-1:0] dir_hi;
    logic [CNT_W-1:0] zero_hi;

    // Saturating, so a pin held for hours never wraps into a false hold
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        sat_inc = &c ? c : CNT_W'(c + 1'b1);
    endfunction

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hi_cnt  <= '0;
            dir_hi  <= '0;
            zero_hi <= '0;
        end else begin
            hi_cnt  <= !st_r.sclk_s2 ? '0 : sat_inc(hi_cnt);
            dir_hi  <= !st_r.dir_s2 ? '0 : sat_inc(dir_hi);
            zero_hi <= !st_r.zero_s2 ? '0 : sat_inc(zero_hi);
        end
    end

    a_idle_high: assert property (@(posedge core_clk) disable iff (!rst_n) // [R7]
        (st_r.sclk_s2 && hi_cnt > CNT_W'(RECOVERY_CYCS + 1)) |-> data_out)
        else $error("data not high on an idle link");

    a_recov_low: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
        $fell(st_r.sclk_s2) |-> ##1 (!st_r.recovered)[*8])
        else $error("recovery ended too early");

    a_fresh_time: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
        $rose(st_r.recovered) |-> (hi_cnt == CNT_W'(RECOVERY_CYCS)))
        else $error("recovery length wrong");

    a_word_frozen: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12]
        !st_r.recovered |=> $stable(st_r.tx_gray))
        else $error("word changed during recovery");

    a_gray_word: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
        (st_r.recovered && st_r.sclk_s2) |=> (gray2bin(st_r.tx_gray) == $past(rep)))
        else $error("word is not Gray coded position");

    a_dir_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        $rose(st_r.dir_rev) |-> (dir_hi == CNT_W'(DIR_CYCS)))
        else $error("direction reversed after wrong hold");

    a_dir_drop: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        !st_r.dir_s2 |=> !st_r.dir_rev)
        else $error("direction reversal outlived the input");

    a_sense: assert property (@(posedge core_clk) disable iff (!rst_n) // [R5]
        ($stable(st_r.offset) && $stable(st_r.dir_rev)
         && st_r.live == ssiap_word_t'($past(st_r.live) + 1'b1))
        |-> rep == ((st_r.dir_rev ? ssiap_word_t'($past(rep) - 1'b1)
                                  : ssiap_word_t'($past(rep) + 1'b1)) & FW_MASK))
        else $error("position sense wrong");

    a_zero_out: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        st_r.zero_fire |-> (rep == '0))
        else $error("zeroing did not clear position");

    // Core-side guards on timers, the position path, the link clear and the data pin
    a_zero_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        st_r.zero_fire |-> (zero_hi == CNT_W'(ZERO_CYCS)))
        else $error("zeroing after wrong hold time");

    a_fire_needs: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        st_r.zero_fire |-> $past(st_r.zero_s2))
        else $error("zeroing without the input held");

    a_zero_once: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        st_r.zero_fire |=> (!st_r.zero_fire && !st_r.zero_arm))
        else $error("zeroing repeated without a new edge");

    a_zero_offset: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        st_r.zero_fire |-> (st_r.offset == $past(st_r.live)))
        else $error("zero point is not the current position");

    a_zero_arm_clr: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        !st_r.zero_s2 |=> !st_r.zero_arm)
        else $error("zeroing stayed armed after input low");

    a_zero_pop: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        zero_hit |-> !buf_pop)
        else $error("position moved in the zeroing cycle");

    a_dir_early: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        (st_r.dir_s2 && dir_hi < CNT_W'(DIR_CYCS)) |-> !st_r.dir_rev)
        else $error("direction reversed before hold time");

    a_dir_keep: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        (st_r.dir_rev && st_r.dir_s2) |=> st_r.dir_rev)
        else $error("direction reversal dropped while held");

    a_rec_sat: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
        st_r.recovered |-> (st_r.rec_cnt == CNT_W'(RECOVERY_CYCS)))
        else $error("recovered before full interval");

    a_rec_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12]
        !st_r.sclk_s2 |=> (!st_r.recovered && st_r.rec_cnt == '0))
        else $error("low clock did not restart recovery");

    a_link_run: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
        $past(rst_n) |-> !st_r.link_clr)
        else $error("link held clear after reset");

    a_rep_mask: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
        (rep & ~FW_MASK) == '0)
        else $error("position wider than frame");

    a_tx_mask: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
        (st_r.tx_gray & ~FW_MASK) == '0)
        else $error("word wider than frame");

    a_pop_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12]
        !st_r.recovered |=> $stable(st_r.live))
        else $error("position taken while not recovered");

    a_data_low: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
        (!st_r.recovered && !st_r.dout_s2) |=> !data_out)
        else $error("data not low after frame");

    a_data_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // [R7]
        st_r.recovered |=> data_out)
        else $error("data not high once recovered");

    c_frame: cover property (@(posedge core_clk) disable iff (!rst_n)
        $fell(st_r.sclk_s2) ##[1:1000] $rose(st_r.recovered));

    c_repeat: cover property (@(posedge core_clk) disable iff (!rst_n)
        $fell(st_r.sclk_s2) && !st_r.recovered);

    c_zero: cover property (@(posedge core_clk) disable iff (!rst_n)
        st_r.zero_fire);

    c_dir: cover property (@(posedge core_clk) disable iff (!rst_n)
        $rose(st_r.dir_rev));

    c_full: cover property (@(posedge core_clk) disable iff (!rst_n)
        !pos_ready);
endmodule

// ---- dv/ssiap_ctrl_model.sv ----
// Controller-side model: makes the shift clock, reads one frame, decodes Gray.
// Assumes the device shows each bit on data_in within 40 ns of a rising edge.
`timescale 1ns/1ps
module ssiap_ctrl_model
    import ssiap_pkg::*;
#(
    parameter int FW = 13
) (
    // Link pins
    output logic          link_clk,
    input  wire logic     data_in,
    // Received frame
    output logic [FW-1:0] rx_word,
    output logic          rx_tail,
    output logic          rx_done
);
    logic [FW-1:0] gray_r;

    initial begin
        link_clk = 1'b1;
        rx_word  = '0;
        rx_tail  = 1'b0;
        rx_done  = 1'b0;
        gray_r   = '0;
    end

    // Clock stands high between frames; the caller owns the pause length
    task automatic read_frame(input realtime half);
        logic acc;
        acc = 1'b0;
        link_clk = 1'b0;
        #half;
        for (int i = FW - 1; i >= 0; i--) begin
            link_clk = 1'b1;
            #half;
            // Late sample: the device data crosses a synchroniser first
            gray_r[i] = data_in;
            link_clk = 1'b0;
            #half;
        end
        link_clk = 1'b1;
        #half;
        rx_tail = data_in;
        for (int i = FW - 1; i >= 0; i--) begin
            acc = acc ^ gray_r[i];
            rx_word[i] = acc;
        end
        rx_done = 1'b1;
        #half;
        rx_done = 1'b0;
    endtask
endmodule

// ---- dv/ssiap_port_bench.sv ----
// Self-checking bench for the position serial port, 13-bit frame.
// Assumes shortened hold and recovery counts, set below.
`timescale 1ns/1ps
module ssiap_port_bench
    import ssiap_pkg::*;
    ;
    localparam int FW   = 13;
    localparam int REC  = 50;
    localparam int DIRC = 20;
    localparam int ZC   = 30;

    logic          core_clk;
    logic          rst_n;
    logic          link_clk;
    logic          data_out;
    logic          dir_pin;
    logic          zero_pin;
    logic          pos_valid;
    logic          pos_ready;
    ssiap_pos_t    pos_data;
    logic          dir_reversed;
    logic          zero_done;
    logic [FW-1:0] rx_word;
    logic          rx_tail;
    logic          rx_done;
    logic [FW-1:0] exp_q[$];
    logic [FW-1:0] ex;
    ssiap_word_t   p;
    ssiap_word_t   q;
    ssiap_word_t   r;
    int            seed;
    int            fail_count;
    int            compares;
    int            zero_seen;

    ssiap_port #(.MULTITURN(1'b0), .RECOVERY_CYCS(REC), .DIR_CYCS(DIRC),
                 .ZERO_CYCS(ZC)) dut (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .link_clk     (link_clk),
        .data_out     (data_out),
        .dir_pin      (dir_pin),
        .zero_pin     (zero_pin),
        .pos_valid    (pos_valid),
        .pos_ready    (pos_ready),
        .pos_data     (pos_data),
        .dir_reversed (dir_reversed),
        .zero_done    (zero_done)
    );

    ssiap_ctrl_model #(.FW(FW)) ctrl (
        .link_clk (link_clk),
        .data_in  (data_out),
        .rx_word  (rx_word),
        .rx_tail  (rx_tail),
        .rx_done  (rx_done)
    );

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    task automatic check_word(input logic [FW-1:0] got, input logic [FW-1:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Valid and data held until the edge that takes them
    task automatic push(input ssiap_word_t v, input bit hold);
        int n;
        n = 0;
        pos_valid = 1'b1;
        pos_data.count = v;
        while (pos_ready !== 1'b1 && n < 5000) begin
            cyc(1);
            n++;
        end
        if (n == 5000) fail_count++;
        cyc(1);
        if (!hold) pos_valid = 1'b0;
    endtask

    // Odd offset keeps the link clock off the core clock's phase
    task automatic frame(input logic [FW-1:0] e, input realtime half);
        exp_q.push_back(e);
        #3.3;
        ctrl.read_frame(half);
        cyc(1);
    endtask

    always @(posedge rx_done) begin
        if (exp_q.size() == 0) fail_count++;
        else check_word(rx_word, exp_q.pop_front());
        check_bit(rx_tail, 1'b0);
    end

    always @(negedge core_clk) begin
        if (zero_done === 1'b1) zero_seen++;
    end

    initial begin
        #600000;
        fail_count++;
        end_of_test();
    end

    initial begin
        seed = 32'h8f1df839;
        fail_count = 0;
        compares = 0;
        zero_seen = 0;
        rst_n = 1'b0;
        dir_pin = 1'b0;
        zero_pin = 1'b0;
        pos_valid = 1'b0;
        pos_data = '0;
        cyc(16);
        rst_n = 1'b1;
        cyc(4);
        check_bit(data_out, DATA_IDLE);
        for (int i = 0; i < 4; i++) begin
            p = ssiap_word_t'($random(seed));
            push(p, 1'b0);
            cyc(10);
            frame(p[FW-1:0], i[0] ? 125.0 : 62.5);
            cyc(REC + 20);
            check_bit(data_out, 1'b1);
        end
        $display("done: stream");
        p = ssiap_word_t'($random(seed));
        q = ssiap_word_t'($random(seed));
        r = ssiap_word_t'($random(seed));
        push(p, 1'b0);
        cyc(10);
        frame(p[FW-1:0], 62.5);
        push(q, 1'b1);
        push(r, 1'b0);
        check_bit(pos_ready, 1'b0);
        frame(p[FW-1:0], 62.5);
        cyc(REC + 30);
        check_bit(pos_ready, 1'b1);
        frame(r[FW-1:0], 62.5);
        cyc(REC + 20);
        $display("done: recovery");
        zero_pin = 1'b1;
        cyc(ZC - 5);
        zero_pin = 1'b0;
        cyc(ZC);
        check_bit(zero_seen == 0, 1'b1);
        zero_pin = 1'b1;
        cyc(ZC - 3);
        check_bit(zero_seen == 0, 1'b1);
        cyc(10);
        check_bit(zero_seen == 1, 1'b1);
        zero_pin = 1'b0;
        cyc(10);
        frame('0, 62.5);
        cyc(REC + 20);
        q = ssiap_word_t'($random(seed));
        push(q, 1'b0);
        cyc(10);
        ex = q[FW-1:0] - r[FW-1:0];
        frame(ex, 62.5);
        cyc(REC + 20);
        $display("done: zeroing");
        dir_pin = 1'b1;
        cyc(DIRC - 5);
        check_bit(dir_reversed, 1'b0);
        dir_pin = 1'b0;
        cyc(4);
        dir_pin = 1'b1;
        cyc(DIRC + 8);
        check_bit(dir_reversed, 1'b1);
        frame('0 - ex, 62.5);
        cyc(REC + 20);
        dir_pin = 1'b0;
        cyc(6);
        check_bit(dir_reversed, 1'b0);
        frame(ex, 62.5);
        cyc(REC + 20);
        $display("done: direction");
        check_bit(exp_q.size() == 0, 1'b1);
        end_of_test();
    end
endmodule
